// *** hdl/timer8_top.sv ***
`timescale 1ns/1ps
`include "timer8_consts.svh"
`default_nettype none
module timer8_top (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write channels.
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // External event pin, watchdog link and overflow interrupt request.
  input  wire logic        external_timer_clock_pin,
  output var  logic        watchdog_tick,
  output var  logic        overflow_irq
);

  // Register index from a byte address; unaligned or out-of-range gives an illegal index.
  function automatic logic [8:0] reg_index(input logic [31:0] addr);
    if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0) begin
      reg_index = 9'h1FF;
    end else begin
      reg_index = {1'b0, addr[9:2]};
    end
  endfunction : reg_index

  logic [7:0] timer_count;
  logic [7:0] option_config;
  logic [7:0] interrupt_control;
  logic [5:0] port_a_direction;
  logic       sleep_mode;
  logic [7:0] prescaler;
  logic [1:0] holdoff;
  logic [2:0] pin_sync;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic        aw_held;
  logic        w_held;
  logic        w_lane0;
  timer8_pkg::wr_state_t wr_state;

  wire logic       clock_source_select  = option_config[`OPT_CS_BIT];
  wire logic       source_edge_select   = option_config[`OPT_SE_BIT];
  wire logic       prescaler_assignment = option_config[`OPT_PSA_BIT];
  wire logic [2:0] prescale_ratio_field = option_config[`OPT_PS_MSB:0];

  // Write is committed once address and data are both held.
  wire logic       wr_fire  = aw_held && w_held && (wr_state == timer8_pkg::WR_IDLE);
  wire logic [8:0] wr_idx   = reg_index(aw_addr);
  wire logic       wr_lane  = wr_fire && w_held;
  logic            wr_strb0;
  wire logic       wr_count = wr_fire && wr_strb0 && (wr_idx == {1'b0, `REG_TIMER_COUNT_IDX});
  wire logic       wr_ctrl  = wr_fire && wr_strb0 && (wr_idx == {1'b0, `REG_CORE_CTRL_IDX});
  wire logic       wdt_clear = wr_ctrl && w_data[`CTRL_WDT_CLR_BIT];

  // Pin edge from the two-stage synchroniser; only stage two onward are compared.
  wire logic pin_rise   = pin_sync[1] && !pin_sync[2];
  wire logic pin_fall   = !pin_sync[1] && pin_sync[2];
  wire logic pin_edge   = source_edge_select ? pin_fall : pin_rise;
  // Source clock: instruction cycle or external edge.
  wire logic src_tick   = clock_source_select ? pin_edge : 1'b1;

  // Prescaler output: bit n of the running count wraps every 2^(n+1) inputs.
  wire logic [7:0] next_prescaler = prescaler + 8'h01;
  wire logic       ps_wrap        = (next_prescaler[prescale_ratio_field] == 1'b0) &&
                                    prescaler[prescale_ratio_field];
  wire logic       timer_tick = prescaler_assignment ? src_tick : (src_tick && ps_wrap);
  wire logic       count_en   = timer_tick && (holdoff == 2'h0) && !sleep_mode;

  // Watchdog postscaler wraps every 2^n raw watchdog ticks, so n = 0 passes every tick.
  logic wdt_raw;
  wire logic wdt_wrap = (prescale_ratio_field == 3'h0) ? 1'b1 :
                        ((next_prescaler[prescale_ratio_field - 3'h1] == 1'b0) &&
                         prescaler[prescale_ratio_field - 3'h1]);

  // Lane 0 enable as captured with the data; the live strobe may already belong to the next beat.
  always_comb begin
    wr_strb0 = w_lane0;
  end

  // Synchroniser for the external pin; the first stage feeds only the second.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], external_timer_clock_pin};
    end
  end

  // Raw watchdog tick: a free divider stands in for the watchdog oscillator.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wdt_raw <= 1'b0;
    end else begin
      wdt_raw <= !wdt_raw;
    end
  end

  // Shared prescaler. It has no bus address, so software can never see it.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prescaler <= 8'h00;
    end else if (!prescaler_assignment && wr_count) begin
      prescaler <= 8'h00;
    end else if (prescaler_assignment && wdt_clear) begin
      prescaler <= 8'h00;
    end else if (prescaler_assignment ? wdt_raw : (src_tick && !sleep_mode)) begin
      prescaler <= next_prescaler;
    end
  end

  // Watchdog tick output; the assignment bit is read live, so switching needs no stop.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      watchdog_tick <= 1'b0;
    end else begin
      watchdog_tick <= prescaler_assignment ? (wdt_raw && wdt_wrap) : wdt_raw;
    end
  end

  // Hold-off counter restarted by every count write.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      holdoff <= 2'h0;
    end else if (wr_count) begin
      holdoff <= `WRITE_HOLDOFF;
    end else if (holdoff != 2'h0) begin
      holdoff <= holdoff - 2'h1;
    end
  end

  // Count register: a write wins over an increment in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_count <= 8'h00;
    end else if (wr_count) begin
      timer_count <= w_data[7:0];
    end else if (count_en) begin
      timer_count <= timer_count + 8'h01;
    end
  end

  // Interrupt control: rollover sets the flag, and the set wins over a software clear.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      interrupt_control <= `INT_RESET;
    end else begin
      if (wr_fire && wr_strb0 && wr_idx == {1'b0, `REG_INTERRUPT_IDX}) begin
        interrupt_control <= w_data[7:0];
      end
      if (count_en && timer_count == 8'hFF) begin
        interrupt_control[`INT_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Option, port direction and sleep control.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      option_config    <= `OPT_RESET;
      port_a_direction <= `PORT_A_DIR_RESET;
      sleep_mode       <= 1'b0;
    end else if (wr_fire && wr_strb0) begin
      if (wr_idx == {1'b0, `REG_OPTION_IDX}) begin
        option_config <= w_data[7:0];
      end
      if (wr_idx == {1'b0, `REG_PORT_A_DIR_IDX}) begin
        port_a_direction <= w_data[5:0];
      end
      if (wr_ctrl) begin
        sleep_mode <= w_data[`CTRL_SLEEP_BIT];
      end
    end
  end

  // Interrupt request: flag gated by its enable and the global enable.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= interrupt_control[`INT_FLAG_BIT] && interrupt_control[`INT_EN_BIT] &&
                      interrupt_control[`INT_GIE_BIT];
    end
  end

  // Write channel: address and data are captured in either order, then answered.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 32'h0;
      w_data        <= 32'h0;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      wr_state      <= timer8_pkg::WR_IDLE;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      case (wr_state)
        timer8_pkg::WR_IDLE: begin
          if (wr_lane) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx == {1'b0, `REG_TIMER_COUNT_IDX} || wr_idx == {1'b0, `REG_INTERRUPT_IDX} ||
                             wr_idx == {1'b0, `REG_OPTION_IDX} || wr_idx == {1'b0, `REG_PORT_A_DIR_IDX} ||
                             wr_idx == {1'b0, `REG_CORE_CTRL_IDX}) ? `AXI_OKAY : `AXI_SLVERR;
            wr_state     <= timer8_pkg::WR_RESP;
          end
        end
        timer8_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            wr_state     <= timer8_pkg::WR_IDLE;
          end
        end
        default: begin
          wr_state <= timer8_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // Read channel: one cycle from address to data; unmapped reads answer SLVERR.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `AXI_OKAY;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `AXI_OKAY;
      case (reg_index(s_axi_araddr))
        {1'b0, `REG_TIMER_COUNT_IDX}: s_axi_rdata <= {24'h0, timer_count};
        {1'b0, `REG_INTERRUPT_IDX}:   s_axi_rdata <= {24'h0, interrupt_control};
        {1'b0, `REG_OPTION_IDX}:      s_axi_rdata <= {24'h0, option_config};
        {1'b0, `REG_PORT_A_DIR_IDX}:  s_axi_rdata <= {26'h0, port_a_direction};
        {1'b0, `REG_CORE_CTRL_IDX}:   s_axi_rdata <= {31'h0, sleep_mode};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `AXI_SLVERR;
        end
      endcase
    end else begin
      s_axi_arready <= s_axi_arvalid;
    end
  end

  // Checks kept next to the logic.
  overflow_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (count_en && !wr_count && timer_count == 8'hFF) |=>
    (timer_count == 8'h00 && interrupt_control[`INT_FLAG_BIT]))
    else $error("Rollover did not set the overflow flag.");
  // The written value lands first, so stability is only asked of the two held-off cycles after it.
  write_holdoff_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_count |=> !count_en ##1 (!count_en && $stable(timer_count)) ##1 $stable(timer_count))
    else $error("Count moved within two cycles of a write.");
  sleep_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sleep_mode && !wr_count) |=> $stable(timer_count))
    else $error("Count moved during sleep.");
  irq_mask_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !interrupt_control[`INT_EN_BIT] |=> !overflow_irq)
    else $error("Masked overflow raised the interrupt.");
  prescale_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_count && !prescaler_assignment) |=> prescaler == 8'h00)
    else $error("Count write did not clear the prescaler.");
  wdt_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wdt_clear && prescaler_assignment) |=> prescaler == 8'h00)
    else $error("Watchdog clear did not clear the prescaler.");
  timer_rate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!clock_source_select && prescaler_assignment && holdoff == 2'h0 && !sleep_mode && !wr_count)
    |=> timer_count == $past(timer_count) + 8'h01)
    else $error("Timer mode missed an instruction cycle.");
  edge_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clock_source_select && !pin_edge && !wr_count) |=> $stable(timer_count))
    else $error("Counter moved without a selected pin edge.");
  option_reset_a: assert property (@(posedge sys_clk)
    sys_rst |=> option_config == `OPT_RESET)
    else $error("Option register not all ones after reset.");
  // At 1:2 only every second instruction cycle may reach the count.
  prescale_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!clock_source_select && !prescaler_assignment && prescale_ratio_field == 3'h0 &&
     !prescaler[0] && !wr_count) |=> $stable(timer_count))
    else $error("Prescaled timer counted on a skipped cycle.");
  // With the prescaler on the timer the watchdog sees every raw tick.
  watchdog_raw_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !prescaler_assignment |=> watchdog_tick == $past(wdt_raw))
    else $error("Watchdog tick divided while prescaler served the timer.");

endmodule : timer8_top
`default_nettype wire

// *** hdl/timer8_consts.svh ***
`ifndef TIMER8_CONSTS_SVH
`define TIMER8_CONSTS_SVH
// Register offsets; printed offsets are not all multiples of four, so they are indices.
`define REG_TIMER_COUNT_IDX   8'h01
`define REG_INTERRUPT_IDX     8'h0B
`define REG_OPTION_IDX        8'h81
`define REG_PORT_A_DIR_IDX    8'h85
// Control register of our own: bit 0 sleep, bit 1 watchdog clear (self-clearing).
`define REG_CORE_CTRL_IDX     8'hC0
// Option register fields.
`define OPT_CS_BIT            5
`define OPT_SE_BIT            4
`define OPT_PSA_BIT           3
`define OPT_PS_MSB            2
`define OPT_RESET             8'hFF
// Interrupt control fields.
`define INT_FLAG_BIT          2
`define INT_EN_BIT            5
`define INT_GIE_BIT           7
`define INT_RESET             8'h00
`define PORT_A_DIR_RESET      6'h3F
`define CTRL_SLEEP_BIT        0
`define CTRL_WDT_CLR_BIT      1
// Cycles of increment hold-off after a count write.
`define WRITE_HOLDOFF         2'h2
`define AXI_OKAY              2'h0
`define AXI_SLVERR            2'h2
`endif

// *** hdl/timer8_pkg.sv ***
`default_nettype none
package timer8_pkg;
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_t;
endpackage : timer8_pkg
`default_nettype wire

// *** tb/event_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module event_source (
  // Clock that times each level change.
  input  wire logic sys_clk,
  // Event line into the counter pin.
  output var  logic pin
);
  initial pin = 1'b0;

  // Each level is held eight cycles, long enough for the pin synchroniser to see it.
  task automatic drive(input logic level);
    @(posedge sys_clk);
    pin <= level;
    repeat (8) @(posedge sys_clk);
  endtask : drive
endmodule : event_source
`default_nettype wire

// *** tb/timer8_top_test.sv ***
`timescale 1ns/1ps
`include "timer8_consts.svh"
`default_nettype none
module timer8_top_test;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        external_timer_clock_pin;
  logic        watchdog_tick;
  logic        overflow_irq;
  logic [1:0]  bresp_seen;
  logic [1:0]  rresp_seen;
  int          bad_count = 0;
  int          checked = 0;
  int          cycles = 0;

  timer8_top dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .external_timer_clock_pin, .watchdog_tick, .overflow_irq);
  event_source src (.sys_clk, .pin(external_timer_clock_pin));

  // Clock of 40 ns period.
  always #20 sys_clk = ~sys_clk;

  // A hang is cut short well after the longest expected run.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Address and data go out together; each is dropped once its ready is sampled.
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge sys_clk);
    s_axi_awaddr  <= {22'h0, idx, 2'h0};
    s_axi_wdata   <= {24'h0, val};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    bresp_seen = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] data);
    @(posedge sys_clk);
    s_axi_araddr  <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    data = s_axi_rdata;
    rresp_seen = s_axi_rresp;
  endtask : rd

  // Cycles from a count write until the request shows; the flag is then cleared.
  task automatic irq_delay(input logic [7:0] start, output int n);
    wr(`REG_TIMER_COUNT_IDX, start);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (overflow_irq !== 1'b1 && n < 2000);
    wr(`REG_INTERRUPT_IDX, 8'hA0);
  endtask : irq_delay

  // Cycles between two watchdog pulses.
  task automatic tick_gap(output int n);
    n = 0;
    do @(posedge sys_clk); while (watchdog_tick !== 1'b1);
    do begin
      @(posedge sys_clk);
      n++;
    end while (watchdog_tick !== 1'b1 && n < 600);
  endtask : tick_gap

  task automatic t_reset();
    logic [31:0] d;
    rd(`REG_OPTION_IDX, d);
    check(d, 32'h0000_00FF);
    rd(`REG_INTERRUPT_IDX, d);
    check(d, 32'h0000_0000);
    rd(`REG_PORT_A_DIR_IDX, d);
    check(d, 32'h0000_003F);
    rd(8'h02, d);
    check(32'(rresp_seen), 32'(`AXI_SLVERR));
    wr(8'h02, 8'h55);
    check(32'(bresp_seen), 32'(`AXI_SLVERR));
  endtask : t_reset

  // Timing of the overflow request without the prescaler and at prescale 1:2 and 1:256.
  task automatic t_timer();
    int a;
    int b;
    wr(`REG_INTERRUPT_IDX, 8'hA0);
    wr(`REG_OPTION_IDX, 8'h08);
    irq_delay(8'hFE, a);
    check(32'(a), 32'h5);
    irq_delay(8'hFD, b);
    check(32'(b - a), 32'h1);
    wr(`REG_OPTION_IDX, 8'h00);
    irq_delay(8'hFE, a);
    irq_delay(8'hFD, b);
    check(32'(b - a), 32'h2);
    wr(`REG_OPTION_IDX, 8'h07);
    irq_delay(8'hFE, a);
    irq_delay(8'hFD, b);
    check(32'(b - a), 32'h100);
    irq_delay(8'hFE, b);
    check(32'(b), 32'(a));
  endtask : t_timer

  task automatic t_mask_sleep();
    logic [31:0] d;
    logic [31:0] e;
    wr(`REG_INTERRUPT_IDX, 8'h80);
    wr(`REG_TIMER_COUNT_IDX, 8'h00);
    wr(`REG_CORE_CTRL_IDX, 8'h02);
    wr(`REG_OPTION_IDX, 8'h08);
    wr(`REG_TIMER_COUNT_IDX, 8'hFE);
    repeat (10) @(posedge sys_clk);
    check(32'(overflow_irq), 32'h0);
    rd(`REG_INTERRUPT_IDX, d);
    check(d, 32'h0000_0084);
    wr(`REG_CORE_CTRL_IDX, 8'h01);
    rd(`REG_TIMER_COUNT_IDX, d);
    repeat (20) @(posedge sys_clk);
    rd(`REG_TIMER_COUNT_IDX, e);
    check(e, d);
    wr(`REG_CORE_CTRL_IDX, 8'h00);
  endtask : t_mask_sleep

  // One level change at a time shows which edge is counted.
  task automatic t_counter();
    logic [31:0] d;
    wr(`REG_OPTION_IDX, 8'h28);
    wr(`REG_TIMER_COUNT_IDX, 8'h00);
    src.drive(1'b1);
    rd(`REG_TIMER_COUNT_IDX, d);
    check(d, 32'h1);
    src.drive(1'b0);
    rd(`REG_TIMER_COUNT_IDX, d);
    check(d, 32'h1);
    wr(`REG_OPTION_IDX, 8'h38);
    src.drive(1'b1);
    rd(`REG_TIMER_COUNT_IDX, d);
    check(d, 32'h1);
    src.drive(1'b0);
    rd(`REG_TIMER_COUNT_IDX, d);
    check(d, 32'h2);
  endtask : t_counter

  task automatic t_watchdog();
    int n;
    wr(`REG_OPTION_IDX, 8'h08);
    tick_gap(n);
    check(32'(n), 32'h2);
    wr(`REG_OPTION_IDX, 8'h0B);
    tick_gap(n);
    check(32'(n), 32'h10);
    tick_gap(n);
    repeat (6) @(posedge sys_clk);
    wr(`REG_CORE_CTRL_IDX, 8'h02);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (watchdog_tick !== 1'b1 && n < 600);
    check(32'(n >= 12), 32'h1);
    wr(`REG_OPTION_IDX, 8'h07);
    tick_gap(n);
    check(32'(n), 32'h2);
  endtask : t_watchdog

  // Reset for 20 cycles, then every scenario in turn.
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_timer();
    t_mask_sleep();
    t_counter();
    t_watchdog();
    give_verdict();
  end
endmodule : timer8_top_test
`default_nettype wire
